// >>> bench/fcd_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side of the issue path: offers a word and holds it until taken
module fcd_host_model (
   // Clock
   input  wire logic        mclk,
   // Issue path
   output logic             instr_valid,
   output logic [31:0]      instr,
   output logic             cond_pass,
   input  wire logic        instr_ready,
   input  wire logic        done,
   input  wire logic        undef
);
   initial begin
      instr_valid = 1'b0;
      instr       = 32'h0;
      cond_pass   = 1'b0;
   end

   // Offer, wait for the take, then wait for the completion pulse
   task automatic issue(input logic [31:0] w, input logic c,
                        output logic got, output logic und);
      int n;
      got = 1'b0;
      und = 1'b0;
      n = 0;
      @(posedge mclk);
      #1;
      instr_valid = 1'b1;
      instr       = w;
      cond_pass   = c;
      while (instr_ready !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1;
         n++;
      end
      @(posedge mclk);
      #1;
      // Released lines no longer show the last value
      instr_valid = 1'b0;
      instr       = ~w;
      cond_pass   = ~c;
      repeat (8) begin
         if (!got) begin
            @(posedge mclk);
            #1;
            got = (done === 1'b1);
            und = undef;
         end
      end
   endtask : issue
endmodule : fcd_host_model
`default_nettype wire

// >>> bench/fp_coproc_move_convert_decode_bench.sv
`timescale 1ns/1ns
`default_nettype none
module fp_coproc_move_convert_decode_bench;
   logic        mclk;
   logic        arst_n;
   logic        ce;
   logic        instr_valid;
   logic [31:0] instr;
   logic        cond_pass;
   logic        instr_ready;
   logic        done;
   logic        undef;
   logic        ld_valid;
   logic [3:0]  ld_sel;
   logic [63:0] ld_data;
   logic [3:0]  rd_sel;
   logic [63:0] rd_data;
   logic [3:0]  acc_sel;
   logic [71:0] acc_data;
   logic [63:0] scr;
   logic        got;
   logic        und;
   logic [63:0] v;
   logic [71:0] a;
   int          errors;
   int          n_compared;

   fcd_move_convert fcd_move_convert_i (
      .mclk(mclk), .arst_n(arst_n), .ce(ce),
      .instr_valid(instr_valid), .instr(instr), .cond_pass(cond_pass),
      .instr_ready(instr_ready), .done(done), .undef(undef),
      .ld_valid(ld_valid), .ld_sel(ld_sel), .ld_data(ld_data),
      .rd_sel(rd_sel), .rd_data(rd_data), .acc_sel(acc_sel),
      .acc_data(acc_data), .status_control_reg(scr)
   );

   fcd_host_model fcd_host_model_i (
      .mclk(mclk), .instr_valid(instr_valid), .instr(instr),
      .cond_pass(cond_pass), .instr_ready(instr_ready), .done(done),
      .undef(undef)
   );

   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic print_verdict;
      if (errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   // Word of this group: fixed codes, flag bit clear
   function automatic logic [31:0] mk(input logic [1:0] dir,
      input logic [3:0] s, input logic [3:0] d, input logic [7:0] gs);
      return {4'he, 4'he, 2'h0, dir, s, d, gs[7:4], gs[2:0], 1'b0, 4'h0};
   endfunction : mk

   task automatic ld(input logic [3:0] sel, input logic [63:0] data);
      @(posedge mclk);
      #1;
      ld_valid = 1'b1;
      ld_sel   = sel;
      ld_data  = data;
      @(posedge mclk);
      #1;
      ld_valid = 1'b0;
   endtask : ld

   task automatic rd(input logic [3:0] sel, output logic [63:0] q);
      @(posedge mclk);
      #1;
      rd_sel = sel;
      @(posedge mclk);
      #1;
      q = rd_data;
   endtask : rd

   task automatic rda(input logic [3:0] sel, output logic [71:0] q);
      @(posedge mclk);
      #1;
      acc_sel = sel;
      @(posedge mclk);
      #1;
      q = acc_data;
   endtask : rda

   task automatic iss(input logic [31:0] w, input logic c);
      fcd_host_model_i.issue(w, c, got, und);
      chk(got, 1'b1);
   endtask : iss

   // Source in r1, destination r2 preset so untouched halves show
   task automatic conv(input logic [7:0] gs, input logic [63:0] src,
                       input logic [63:0] exp);
      ld(4'h1, src);
      ld(4'h2, 64'h5555_5555_5555_5555);
      iss(mk(gs[4] ? 2'h1 : 2'h0, 4'h1, 4'h2, gs), 1'b1);
      rd(4'h2, v);
      chk(v, exp);
      chk(und, 1'b0);
   endtask : conv

   task automatic t_convert;
      conv(8'h40, 64'h3f80_0000_1234_5678, 64'h3f80_0000_5555_5555);
      conv(8'h41, 64'hc004_0000_0000_0001, 64'hc004_0000_0000_0001);
      conv(8'h43, 64'h3f80_0000_0000_0000, 64'h3ff0_0000_0000_0000);
      conv(8'h42, 64'h3ff8_0000_0000_0000, 64'h3fc0_0000_5555_5555);
      conv(8'h44, 64'h0000_0000_ffff_fffd, 64'hc040_0000_5555_5555);
      conv(8'h45, 64'h0000_0000_0000_0003, 64'h4008_0000_0000_0000);
      conv(8'h46, 64'h0000_0001_0000_0000, 64'h4f80_0000_5555_5555);
      conv(8'h47, 64'hffff_ffff_ffff_fffe, 64'hc000_0000_0000_0000);
      conv(8'h54, 64'h4060_0000_0000_0000, 64'h5555_5555_0000_0004);
      conv(8'h55, 64'h4004_0000_0000_0000, 64'h5555_5555_0000_0002);
      conv(8'h56, 64'hc060_0000_0000_0000, 64'h5555_5555_ffff_fffd);
      conv(8'h57, 64'h400c_0000_0000_0000, 64'h5555_5555_0000_0003);
   endtask : t_convert

   task automatic t_acc;
      ld(4'h4, 64'h0123_4567_8000_0001);
      iss(mk(2'h2, 4'h4, 4'h1, 8'h45), 1'b1);
      rda(4'h1, a);
      chk(a, 72'hff_ffff_ffff_8000_0001);
      ld(4'h5, 64'h5555_5555_5555_5555);
      iss(mk(2'h1, 4'h1, 4'h5, 8'h45), 1'b1);
      rd(4'h5, v);
      chk(v, 64'h5555_5555_8000_0001);
      ld(4'h6, 64'h8000_0000_0000_0000);
      iss(mk(2'h2, 4'h6, 4'h2, 8'h46), 1'b1);
      rda(4'h2, a);
      chk(a, 72'hff_8000_0000_0000_0000);
      iss(mk(2'h1, 4'h2, 4'h5, 8'h45), 1'b1);
      rd(4'h5, v);
      chk(v, 64'h5555_5555_8000_0000);
      iss(mk(2'h1, 4'h2, 4'h5, 8'h46), 1'b1);
      rd(4'h5, v);
      chk(v, 64'h8000_0000_0000_0000);
   endtask : t_acc

   task automatic t_status;
      ld(4'h7, 64'hc3a5_5a3c_0f1e_2d4b);
      iss(mk(2'h2, 4'h9, 4'h7, 8'h47), 1'b1);
      chk(scr, 64'hc3a5_5a3c_0f1e_2d4b);
      iss(mk(2'h1, 4'h3, 4'h8, 8'h47), 1'b1);
      rd(4'h8, v);
      chk(v, 64'hc3a5_5a3c_0f1e_2d4b);
   endtask : t_status

   // Failed condition and foreign encodings leave the target alone
   task automatic t_refuse;
      ld(4'h9, 64'h1111_2222_3333_4444);
      ld(4'ha, 64'h5555_5555_5555_5555);
      iss(mk(2'h0, 4'h9, 4'ha, 8'h41), 1'b0);
      chk(und, 1'b0);
      iss(mk(2'h0, 4'h9, 4'ha, 8'h41) | 32'h10, 1'b1);
      chk(und, 1'b1);
      iss(mk(2'h0, 4'h9, 4'ha, 8'h41) ^ 32'h0100_0000, 1'b1);
      chk(und, 1'b1);
      iss(mk(2'h3, 4'h9, 4'ha, 8'h41), 1'b1);
      chk(und, 1'b1);
      rd(4'ha, v);
      chk(v, 64'h5555_5555_5555_5555);
   endtask : t_refuse

   // Clock enable low blocks a load; state holds until ce returns
   task automatic t_freeze;
      ld(4'hb, 64'h0);
      ce = 1'b0;
      ld(4'hb, 64'h1234_5678_9abc_def0);
      ce = 1'b1;
      rd(4'hb, v);
      chk(v, 64'h0);
   endtask : t_freeze

   initial begin
      errors     = 0;
      n_compared = 0;
      arst_n     = 1'b0;
      ce         = 1'b1;
      ld_valid   = 1'b0;
      ld_sel     = 4'h0;
      ld_data    = 64'h0;
      rd_sel     = 4'h0;
      acc_sel    = 4'h0;
      repeat (5) @(posedge mclk);
      #1;
      arst_n = 1'b1;
      chk(instr_ready, 1'b1);
      t_freeze;
      t_convert;
      t_acc;
      t_status;
      t_refuse;
      print_verdict;
   end

   // Watchdog well past the roughly 180 cycles the tests need
   initial begin
      #100000;
      errors++;
      print_verdict;
   end
endmodule : fp_coproc_move_convert_decode_bench
`default_nettype wire

// >>> src/fcd_defines.svh
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH

// Instruction fields
`define FCD_F_COND  31:28
`define FCD_F_COP   27:24
`define FCD_F_RSV   23:22
`define FCD_F_DIR   21:20
`define FCD_F_SRC   19:16
`define FCD_F_DST   15:12
`define FCD_F_GRP   11:8
`define FCD_F_SUB   7:5
`define FCD_B_FLAG  4
`define FCD_F_AUX   3:0

// Fixed field values of this group
`define FCD_COP_CODE  4'he
`define FCD_RSV_CODE  2'h0
`define FCD_FLAG_CODE 1'h0

// Decode keys {group, direction, sub-op}
`define FCD_K_CPYS  9'h080
`define FCD_K_CPYD  9'h081
`define FCD_K_D2S   9'h082
`define FCD_K_S2D   9'h083
`define FCD_K_I32S  9'h084
`define FCD_K_I32D  9'h085
`define FCD_K_I64S  9'h086
`define FCD_K_I64D  9'h087
`define FCD_K_A2R32 9'h08d
`define FCD_K_A2R64 9'h08e
`define FCD_K_SCR   9'h08f
`define FCD_K_R2A32 9'h095
`define FCD_K_R2A64 9'h096
`define FCD_K_SCW   9'h097
`define FCD_K_S2I   9'h0ac
`define FCD_K_D2I   9'h0ad
`define FCD_K_TS2I  9'h0ae
`define FCD_K_TD2I  9'h0af

// Register halves and widths
`define FCD_HI      63:32
`define FCD_LO      31:0
`define FCD_REG_W   64
`define FCD_WORD_W  32
`define FCD_ACC_W   72
`define FCD_NREG    16
`define FCD_NACC    4

// Float formats
`define FCD_SP_EW   8
`define FCD_SP_MW   23
`define FCD_DP_EW   11
`define FCD_DP_MW   52
`define FCD_SP_EMAX 8'hff
`define FCD_DP_EMAX 11'h7ff
`define FCD_SD_BIAS 896
`define FCD_SD_SHIFT 29

// Saturation limits
`define FCD_I32_MAX 32'h7fff_ffff
`define FCD_I32_MIN 32'h8000_0000
`define FCD_I64_MAX 64'h7fff_ffff_ffff_ffff
`define FCD_I64_MIN 64'h8000_0000_0000_0000

`endif

// >>> src/fcd_fp2int.sv
`timescale 1ns/1ns
`default_nettype none
`include "fcd_defines.svh"
module fcd_fp2int #(
   parameter int EW = 8,
   parameter int MW = 23
) (
   // Float in
   input  wire logic [EW+MW:0]  fval,
   input  wire logic            trunc,
   // Saturated 32-bit integer out
   output logic      [31:0]     ival
);
   localparam int BIAS = (1 << (EW - 1)) - 1;
   localparam int FXW  = MW + 35;

   initial begin
      if (EW < 6 || MW < 1)
         $error("fcd_fp2int: unsupported widths");
   end

   logic              sgn;
   logic [EW-1:0]     ex;
   logic [FXW-1:0]    fx;
   logic [32:0]       mag;
   logic              up;
   int                e;

   always_comb begin
      sgn = fval[EW+MW];
      ex  = fval[EW+MW-1:MW];
      e   = int'(ex) - BIAS;
      fx  = (e < -2) ? '0 : (FXW'({1'b1, fval[MW-1:0]}) << (e + 2));
      up  = !trunc && fx[MW+1] && ((|fx[MW:0]) || fx[MW+2]);
      mag = {1'b0, fx[MW+2 +: 32]} + 33'(up);
      if (ex == '0)
         ival = '0;
      else if (e > 30 || mag > {1'b0, sgn ? `FCD_I32_MIN : `FCD_I32_MAX})
         ival = sgn ? `FCD_I32_MIN : `FCD_I32_MAX;
      else
         ival = sgn ? 32'(-mag) : mag[31:0];
   end
endmodule : fcd_fp2int
`default_nettype wire

// >>> src/fcd_int2fp.sv
`timescale 1ns/1ns
`default_nettype none
module fcd_int2fp #(
   parameter int IW = 32,
   parameter int EW = 8,
   parameter int MW = 23
) (
   // Signed integer in
   input  wire logic [IW-1:0]    ival,
   // Float out, nearest-even
   output logic      [EW+MW:0]   fval
);
   localparam int BIAS = (1 << (EW - 1)) - 1;
   localparam int XW   = IW + MW + 2;

   initial begin
      if (IW < 2 || EW < 2 || MW < 1 || IW >= (1 << (EW - 1)))
         $error("fcd_int2fp: unsupported widths");
   end

   logic              sgn;
   logic [IW-1:0]     mag;
   logic [XW-1:0]     ext;
   logic [EW+MW-1:0]  body;
   logic              rnd;
   int                p;

   always_comb begin
      sgn = ival[IW-1];
      mag = sgn ? IW'(-ival) : ival;
      p = 0;
      for (int i = 0; i < IW; i++) begin
         if (mag[i])
            p = i;
      end
      ext  = {mag << (IW - 1 - p), {(MW + 2){1'b0}}};
      rnd  = ext[XW-2-MW] && ((|ext[XW-3-MW:0]) || ext[XW-1-MW]);
      body = {EW'(BIAS + p), ext[XW-2 -: MW]} + (EW + MW)'(rnd);
      fval = (mag == '0) ? '0 : {sgn, body};
   end
endmodule : fcd_int2fp
`default_nettype wire

// >>> src/fcd_move_convert.sv
// Functional notes
// - Accumulator to register word: saturate to 32 bits into low half.
// - Register word to accumulator: sign extend 32 bits to 72.
// - Accumulator to register doubleword: saturate to 64 bits.
// - Register doubleword to accumulator: sign extend 64 bits to 72.
// - Status/control write copies register named by dest field; source ignored.
// - Status/control read copies it into dest register; source field ignored.
// - Copy single precision value unchanged.
// - Copy double precision value unchanged.
// - Convert single precision to double precision.
// - Convert double precision to single precision.
// - Convert 32-bit integer to single precision.
// - Convert 32-bit integer to double precision.
// - Convert 64-bit integer to single precision.
// - Convert 64-bit integer to double precision.
// - Convert single precision to 32-bit integer, rounded.
// - Convert double precision to 32-bit integer, rounded.
// - Truncate single precision to 32-bit integer.
// - Truncate double precision to 32-bit integer.
`timescale 1ns/1ns
`default_nettype none
`include "fcd_defines.svh"
module fcd_move_convert
   import fcd_pkg::*;
#(
   parameter int NREG  = `FCD_NREG,
   parameter int NACC  = `FCD_NACC,
   parameter int ACC_W = `FCD_ACC_W
) (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  arst_n,
   input  wire logic                  ce,
   // Instruction issue
   input  wire logic                  instr_valid,
   input  wire logic [31:0]           instr,
   input  wire logic                  cond_pass,
   output logic                       instr_ready,
   output logic                       done,
   output logic                       undef,
   // Register load port
   input  wire logic                  ld_valid,
   input  wire logic [3:0]            ld_sel,
   input  wire logic [`FCD_REG_W-1:0] ld_data,
   // Read-back ports
   input  wire logic [3:0]            rd_sel,
   output logic      [`FCD_REG_W-1:0] rd_data,
   input  wire logic [3:0]            acc_sel,
   output logic      [ACC_W-1:0]      acc_data,
   output logic      [`FCD_REG_W-1:0] status_control_reg
);
   localparam int RIW = $clog2(NREG);
   localparam int AIW = (NACC > 1) ? $clog2(NACC) : 1;

   initial begin
      if (NREG < 2 || NREG > 16 || (1 << RIW) != NREG)
         $error("fcd_move_convert: NREG must be a power of two, 2..16");
      if (NACC < 1 || NACC > 16 || ACC_W <= `FCD_REG_W)
         $error("fcd_move_convert: bad accumulator shape");
   end

   // Storage
   logic [`FCD_REG_W-1:0] reg_mem [NREG];
   logic [ACC_W-1:0]      acc_mem [NACC];
   logic [`FCD_REG_W-1:0] sc_reg;

   // Issue stage
   fcd_state_t            state_reg;
   fcd_op_t               op_reg;
   fcd_op_t               op_next;
   logic                  exec_reg;
   logic [RIW-1:0]        dst_reg;
   logic [AIW-1:0]        dacc_reg;
   logic [`FCD_REG_W-1:0] opa_reg;
   logic [ACC_W-1:0]      acc_reg;
   logic                  accept;
   logic                  wb;

   // Write-back values
   logic [`FCD_REG_W-1:0] res;
   logic [ACC_W-1:0]      acc_res;
   logic                  wr_hi;
   logic                  wr_lo;
   logic                  wr_acc;
   logic                  wr_sc;

   // Converter outputs
   logic [`FCD_WORD_W-1:0] i32s_f;
   logic [`FCD_REG_W-1:0]  i32d_f;
   logic [`FCD_WORD_W-1:0] i64s_f;
   logic [`FCD_REG_W-1:0]  i64d_f;
   logic [`FCD_WORD_W-1:0] s2i_v;
   logic [`FCD_WORD_W-1:0] d2i_v;
   logic [`FCD_REG_W-1:0]  s2d_f;
   logic [`FCD_WORD_W-1:0] d2s_f;

   function automatic logic [`FCD_WORD_W-1:0] sat32(
      input logic [ACC_W-1:0] a);
      logic [ACC_W-1:0] lim;
      lim = ACC_W'($signed(`FCD_I32_MIN));
      if ($signed(a) < $signed(lim))
         return `FCD_I32_MIN;
      else if ($signed(a) > $signed(ACC_W'(`FCD_I32_MAX)))
         return `FCD_I32_MAX;
      else
         return a[`FCD_LO];
   endfunction : sat32

   function automatic logic [`FCD_REG_W-1:0] sat64(
      input logic [ACC_W-1:0] a);
      logic [ACC_W-1:0] lim;
      lim = ACC_W'($signed(`FCD_I64_MIN));
      if ($signed(a) < $signed(lim))
         return `FCD_I64_MIN;
      else if ($signed(a) > $signed(ACC_W'(`FCD_I64_MAX)))
         return `FCD_I64_MAX;
      else
         return a[`FCD_REG_W-1:0];
   endfunction : sat64

   assign instr_ready = (state_reg == FCD_ST_IDLE);
   assign accept      = ce && instr_valid && instr_ready;
   assign wb          = ce && (state_reg == FCD_ST_WRITE) && exec_reg;

   // Decode
   always_comb begin
      op_next = FCD_OP_NONE;
      if (instr[`FCD_F_COP] == `FCD_COP_CODE
          && instr[`FCD_F_RSV] == `FCD_RSV_CODE
          && instr[`FCD_B_FLAG] == `FCD_FLAG_CODE) begin
         case ({instr[`FCD_F_GRP], instr[`FCD_F_DIR], instr[`FCD_F_SUB]})
            `FCD_K_A2R32: op_next = FCD_OP_A2R32;
            `FCD_K_R2A32: op_next = FCD_OP_R2A32;
            `FCD_K_A2R64: op_next = FCD_OP_A2R64;
            `FCD_K_R2A64: op_next = FCD_OP_R2A64;
            `FCD_K_SCW:   op_next = FCD_OP_SCW;
            `FCD_K_SCR:   op_next = FCD_OP_SCR;
            `FCD_K_CPYS:  op_next = FCD_OP_CPYS;
            `FCD_K_CPYD:  op_next = FCD_OP_CPYD;
            `FCD_K_S2D:   op_next = FCD_OP_S2D;
            `FCD_K_D2S:   op_next = FCD_OP_D2S;
            `FCD_K_I32S:  op_next = FCD_OP_I32S;
            `FCD_K_I32D:  op_next = FCD_OP_I32D;
            `FCD_K_I64S:  op_next = FCD_OP_I64S;
            `FCD_K_I64D:  op_next = FCD_OP_I64D;
            `FCD_K_S2I:   op_next = FCD_OP_S2I;
            `FCD_K_D2I:   op_next = FCD_OP_D2I;
            `FCD_K_TS2I:  op_next = FCD_OP_TS2I;
            `FCD_K_TD2I:  op_next = FCD_OP_TD2I;
            default:      op_next = FCD_OP_NONE;
         endcase
      end
   end

   // Sequencer
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= FCD_ST_IDLE;
      end else if (ce) begin
         case (state_reg)
            FCD_ST_IDLE:  if (instr_valid) state_reg <= FCD_ST_WRITE;
            FCD_ST_WRITE: state_reg <= FCD_ST_IDLE;
            default:      state_reg <= FCD_ST_IDLE;
         endcase
      end
   end

   // Operand capture
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         op_reg   <= FCD_OP_NONE;
         exec_reg <= 1'b0;
         dst_reg  <= '0;
         dacc_reg <= '0;
         opa_reg  <= '0;
         acc_reg  <= '0;
      end else if (accept) begin
         op_reg   <= op_next;
         exec_reg <= cond_pass && (op_next != FCD_OP_NONE);
         dst_reg  <= RIW'(instr[`FCD_F_DST]);
         dacc_reg <= AIW'(instr[`FCD_F_DST] % 4'(NACC));
         acc_reg  <= acc_mem[AIW'(instr[`FCD_F_SRC] % 4'(NACC))];
         if (op_next == FCD_OP_SCW)
            opa_reg <= reg_mem[RIW'(instr[`FCD_F_DST])];
         else
            opa_reg <= reg_mem[RIW'(instr[`FCD_F_SRC])];
      end
   end

   // Completion pulses
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         done  <= 1'b0;
         undef <= 1'b0;
      end else if (ce) begin
         done  <= (state_reg == FCD_ST_WRITE);
         undef <= (state_reg == FCD_ST_WRITE) && (op_reg == FCD_OP_NONE);
      end
   end

   // Converters
   fcd_int2fp #(.IW(32), .EW(`FCD_SP_EW), .MW(`FCD_SP_MW)) u_i32s (
      .ival (opa_reg[`FCD_LO]),
      .fval (i32s_f)
   );
   fcd_int2fp #(.IW(32), .EW(`FCD_DP_EW), .MW(`FCD_DP_MW)) u_i32d (
      .ival (opa_reg[`FCD_LO]),
      .fval (i32d_f)
   );
   fcd_int2fp #(.IW(64), .EW(`FCD_SP_EW), .MW(`FCD_SP_MW)) u_i64s (
      .ival (opa_reg),
      .fval (i64s_f)
   );
   fcd_int2fp #(.IW(64), .EW(`FCD_DP_EW), .MW(`FCD_DP_MW)) u_i64d (
      .ival (opa_reg),
      .fval (i64d_f)
   );
   fcd_fp2int #(.EW(`FCD_SP_EW), .MW(`FCD_SP_MW)) u_s2i (
      .fval  (opa_reg[`FCD_HI]),
      .trunc (op_reg == FCD_OP_TS2I),
      .ival  (s2i_v)
   );
   fcd_fp2int #(.EW(`FCD_DP_EW), .MW(`FCD_DP_MW)) u_d2i (
      .fval  (opa_reg),
      .trunc (op_reg == FCD_OP_TD2I),
      .ival  (d2i_v)
   );

   // Single to double, exact; denormals flush to signed zero
   always_comb begin
      logic [`FCD_SP_EW-1:0] e;
      e = opa_reg[62:55];
      if (e == '0)
         s2d_f = {opa_reg[63], 63'h0};
      else if (e == `FCD_SP_EMAX)
         s2d_f = {opa_reg[63], `FCD_DP_EMAX, opa_reg[54:32], 29'h0};
      else
         s2d_f = {opa_reg[63], 11'(e) + 11'(`FCD_SD_BIAS),
                  opa_reg[54:32], 29'h0};
   end

   // Double to single, nearest-even; overflow to infinity
   always_comb begin
      int   e;
      logic rnd;
      e   = int'(opa_reg[62:52]) - `FCD_SD_BIAS;
      rnd = opa_reg[`FCD_SD_SHIFT-1]
            && ((|opa_reg[`FCD_SD_SHIFT-2:0]) || opa_reg[`FCD_SD_SHIFT]);
      if (opa_reg[62:52] == `FCD_DP_EMAX)
         d2s_f = {opa_reg[63], `FCD_SP_EMAX,
                  (|opa_reg[51:0]), opa_reg[50:29]};
      else if (e >= int'(`FCD_SP_EMAX))
         d2s_f = {opa_reg[63], `FCD_SP_EMAX, 23'h0};
      else if (e <= 0)
         d2s_f = {opa_reg[63], 31'h0};
      else
         d2s_f = {opa_reg[63], {8'(e), opa_reg[51:29]} + 31'(rnd)};
   end

   // Result selection
   always_comb begin
      res     = '0;
      acc_res = '0;
      wr_hi   = 1'b0;
      wr_lo   = 1'b0;
      wr_acc  = 1'b0;
      wr_sc   = 1'b0;
      case (op_reg)
         FCD_OP_A2R32: begin
            res[`FCD_LO] = sat32(acc_reg);
            wr_lo = 1'b1;
         end
         FCD_OP_A2R64: begin
            res = sat64(acc_reg);
            {wr_hi, wr_lo} = 2'h3;
         end
         FCD_OP_R2A32: begin
            acc_res = ACC_W'($signed(opa_reg[`FCD_LO]));
            wr_acc = 1'b1;
         end
         FCD_OP_R2A64: begin
            acc_res = ACC_W'($signed(opa_reg));
            wr_acc = 1'b1;
         end
         FCD_OP_SCW: wr_sc = 1'b1;
         FCD_OP_SCR: begin
            res = sc_reg;
            {wr_hi, wr_lo} = 2'h3;
         end
         FCD_OP_CPYS: begin
            res[`FCD_HI] = opa_reg[`FCD_HI];
            wr_hi = 1'b1;
         end
         FCD_OP_CPYD: begin
            res = opa_reg;
            {wr_hi, wr_lo} = 2'h3;
         end
         FCD_OP_S2D: begin
            res = s2d_f;
            {wr_hi, wr_lo} = 2'h3;
         end
         FCD_OP_D2S: begin
            res[`FCD_HI] = d2s_f;
            wr_hi = 1'b1;
         end
         FCD_OP_I32S: begin
            res[`FCD_HI] = i32s_f;
            wr_hi = 1'b1;
         end
         FCD_OP_I32D: begin
            res = i32d_f;
            {wr_hi, wr_lo} = 2'h3;
         end
         FCD_OP_I64S: begin
            res[`FCD_HI] = i64s_f;
            wr_hi = 1'b1;
         end
         FCD_OP_I64D: begin
            res = i64d_f;
            {wr_hi, wr_lo} = 2'h3;
         end
         FCD_OP_S2I, FCD_OP_TS2I: begin
            res[`FCD_LO] = s2i_v;
            wr_lo = 1'b1;
         end
         FCD_OP_D2I, FCD_OP_TD2I: begin
            res[`FCD_LO] = d2i_v;
            wr_lo = 1'b1;
         end
         default: ;
      endcase
   end

   // Register file; write-back wins over the load port
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NREG; i++)
            reg_mem[i] <= '0;
      end else if (ce) begin
         if (ld_valid)
            reg_mem[RIW'(ld_sel)] <= ld_data;
         if (wb && wr_hi)
            reg_mem[dst_reg][`FCD_HI] <= res[`FCD_HI];
         if (wb && wr_lo)
            reg_mem[dst_reg][`FCD_LO] <= res[`FCD_LO];
      end
   end

   // Accumulators
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NACC; i++)
            acc_mem[i] <= '0;
      end else if (wb && wr_acc) begin
         acc_mem[dacc_reg] <= acc_res;
      end
   end

   // Status/control, every bit writable
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n)
         sc_reg <= '0;
      else if (wb && wr_sc)
         sc_reg <= opa_reg;
   end

   // Read-back
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data  <= '0;
         acc_data <= '0;
      end else if (ce) begin
         rd_data  <= reg_mem[RIW'(rd_sel)];
         acc_data <= acc_mem[AIW'(acc_sel % 4'(NACC))];
      end
   end

   assign status_control_reg = sc_reg;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence s_issue;
      accept;
   endsequence

   sequence s_wb(fcd_op_t o);
      wb && op_reg == o && !ld_valid;
   endsequence

   issue_done_a: assert property (s_issue ##1 ce |=> done)
      else $error("accepted instruction gave no done pulse");

   skip_keep_a: assert property (
      ce && state_reg == FCD_ST_WRITE && !exec_reg |=> $stable(sc_reg)
         && $stable(acc_mem[0]))
      else $error("skipped instruction changed state");

   acc_sat32_a: assert property (s_wb(FCD_OP_A2R32) |=>
      reg_mem[dst_reg][`FCD_LO] == sat32(acc_reg))
      else $error("accumulator word move wrong");

   acc_sext32_a: assert property (s_wb(FCD_OP_R2A32) |=>
      $signed(acc_mem[dacc_reg]) == $signed(opa_reg[`FCD_LO]))
      else $error("word to accumulator not sign extended");

   acc_sat64_a: assert property (s_wb(FCD_OP_A2R64) |=>
      reg_mem[dst_reg] == sat64(acc_reg))
      else $error("accumulator doubleword move wrong");

   acc_sext64_a: assert property (s_wb(FCD_OP_R2A64) |=>
      $signed(acc_mem[dacc_reg]) == $signed(opa_reg))
      else $error("doubleword to accumulator not sign extended");

   sc_write_a: assert property (s_wb(FCD_OP_SCW) |=>
      status_control_reg == opa_reg)
      else $error("status/control write lost");

   sc_read_a: assert property (s_wb(FCD_OP_SCR) |=>
      reg_mem[dst_reg] == sc_reg)
      else $error("status/control read wrong");

   copy_single_a: assert property (s_wb(FCD_OP_CPYS) |=>
      reg_mem[dst_reg][`FCD_HI] == opa_reg[`FCD_HI])
      else $error("single copy altered value");

   copy_double_a: assert property (s_wb(FCD_OP_CPYD) |=>
      reg_mem[dst_reg] == opa_reg)
      else $error("double copy altered value");

   trunc_dir_a: assert property (s_wb(FCD_OP_TS2I) |->
      ($signed(s2i_v) >= 0) == (!opa_reg[63] || s2i_v == '0))
      else $error("truncation changed sign");
endmodule : fcd_move_convert
`default_nettype wire

// >>> src/fcd_pkg.sv
package fcd_pkg;

   typedef enum logic [4:0] {
      FCD_OP_NONE  = 5'h00,
      FCD_OP_A2R32 = 5'h01,
      FCD_OP_R2A32 = 5'h02,
      FCD_OP_A2R64 = 5'h03,
      FCD_OP_R2A64 = 5'h04,
      FCD_OP_SCW   = 5'h05,
      FCD_OP_SCR   = 5'h06,
      FCD_OP_CPYS  = 5'h07,
      FCD_OP_CPYD  = 5'h08,
      FCD_OP_S2D   = 5'h09,
      FCD_OP_D2S   = 5'h0a,
      FCD_OP_I32S  = 5'h0b,
      FCD_OP_I32D  = 5'h0c,
      FCD_OP_I64S  = 5'h0d,
      FCD_OP_I64D  = 5'h0e,
      FCD_OP_S2I   = 5'h0f,
      FCD_OP_D2I   = 5'h10,
      FCD_OP_TS2I  = 5'h11,
      FCD_OP_TD2I  = 5'h12
   } fcd_op_t;

   typedef enum logic [0:0] {
      FCD_ST_IDLE  = 1'b0,
      FCD_ST_WRITE = 1'b1
   } fcd_state_t;

endpackage : fcd_pkg
